// >>> logic/expander_pkg.sv
// constants shared by the port expander slave and its testbench
// assumes an i2c bus sampled by a fast system clock
package expander_pkg;

  // ----------------------------------------
  // bus addressing
  // ----------------------------------------
  localparam logic [3:0] ADDR_BASE = 4'h7;
  localparam logic [7:0] PTR_INPUT = 8'h00;
  localparam logic [1:0] IDX_INPUT = 2'h0;
  localparam logic [1:0] IDX_OUTPUT = 2'h1;
  localparam logic [1:0] IDX_POLARITY = 2'h2;
  localparam logic [1:0] IDX_CONFIG = 2'h3;

  // ----------------------------------------
  // values after reset, and the bits per byte
  // ----------------------------------------
  localparam logic [7:0] RST_OUTPUT = 8'hff;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'hff;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // slave states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_RECV  = 6'b00_0010,
    ST_ACK   = 6'b00_0100,
    ST_SEND  = 6'b00_1000,
    ST_RACK  = 6'b01_0000,
    ST_OTHER = 6'b10_0000
  } slave_state_e;

endpackage

// >>> logic/sync_two_flop.sv
// two flip-flop synchroniser for signals from outside the clock domain
// assumes inputs may change at any time relative to clock_in
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage_one <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// >>> logic/expander_input_change_interrupt.sv
// eight-line i2c port expander with change alert
// assumes scl, sda, address straps and port lines arrive asynchronously;
// sda and the alert are open drain, resolved outside from the enables
`timescale 1ns/1ps

module expander_input_change_interrupt
  import expander_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [2:0] addr_strap_in,
  input wire logic [7:0] expander_port_lines_in,
  output logic [7:0] expander_port_lines_out,
  output logic [7:0] expander_port_lines_oe_out,
  output logic alert_n_out,
  output logic alert_n_oe_out
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic [2:0] strap_s;
  logic [7:0] pins_s;

  sync_two_flop #(.WIDTH(2), .RESET_VALUE(2'b11)) bus_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  sync_two_flop #(.WIDTH(11), .RESET_VALUE(11'h000)) pin_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({addr_strap_in, expander_port_lines_in}),
    .sync_out({strap_s, pins_s})
  );

  // ----------------------------------------
  // bus edges and conditions
  // ----------------------------------------
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  slave_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic addr_phase;
  logic cmd_phase;
  logic rw_bit;
  logic master_acked;
  logic [7:0] pointer;
  logic [7:0] out_reg;
  logic [7:0] pol_reg;
  logic [7:0] cfg_reg;
  logic [7:0] snapshot;
  logic input_read;
  logic foreign_read_ack;
  logic [7:0] rd_value;
  logic [7:0] next_tx;

  // read data chosen by the pointer's low bits
  always_comb begin
    unique case (pointer[1:0])
      IDX_INPUT: rd_value = pins_s ^ pol_reg;
      IDX_OUTPUT: rd_value = out_reg;
      IDX_POLARITY: rd_value = pol_reg;
      IDX_CONFIG: rd_value = cfg_reg;
    endcase
  end

  assign next_tx = rd_value;

  // ----------------------------------------
  // i2c slave state machine
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_byte <= 8'h00;
      addr_phase <= 1'b0;
      cmd_phase <= 1'b0;
      rw_bit <= 1'b0;
      master_acked <= 1'b0;
      pointer <= RST_POINTER;
      out_reg <= RST_OUTPUT;
      pol_reg <= RST_POLARITY;
      cfg_reg <= RST_CONFIG;
      sda_oe_out <= 1'b0;
      input_read <= 1'b0;
      foreign_read_ack <= 1'b0;
    end else begin
      input_read <= 1'b0;
      foreign_read_ack <= 1'b0;
      if (start_seen) begin
        state <= ST_RECV;
        bit_cnt <= 4'h0;
        addr_phase <= 1'b1;
        cmd_phase <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          ST_RECV: begin
            shift_in <= {shift_in[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RACK: begin
            if (sda_s) begin
              state <= ST_IDLE;
            end
            master_acked <= !sda_s;
          end
          ST_OTHER: begin
            // any other target acking a read address, pointer at 00h
            if (!sda_s && rw_bit && pointer == PTR_INPUT) begin
              foreign_read_ack <= 1'b1;
            end
            state <= ST_IDLE;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state)
          ST_RECV: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (addr_phase) begin
                rw_bit <= shift_in[0];
                if (shift_in[7:1] == {ADDR_BASE, strap_s}) begin
                  state <= ST_ACK;
                  sda_oe_out <= 1'b1;
                end else begin
                  addr_phase <= 1'b0;
                  state <= ST_OTHER;
                end
              end else if (cmd_phase) begin
                // a bare pointer write of 00h only loads the pointer; it does not count as a read
                pointer <= shift_in;
                cmd_phase <= 1'b0;
                state <= ST_ACK;
                sda_oe_out <= 1'b1;
              end else begin
                unique case (pointer[1:0])
                  IDX_OUTPUT: out_reg <= shift_in;
                  IDX_POLARITY: pol_reg <= shift_in;
                  IDX_CONFIG: cfg_reg <= shift_in;
                  default: begin
                  end
                endcase
                state <= ST_ACK;
                sda_oe_out <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (addr_phase && rw_bit) begin
              state <= ST_SEND;
              tx_byte <= {next_tx[6:0], 1'b0};
              sda_oe_out <= !next_tx[7];
              bit_cnt <= 4'h1;
              input_read <= (pointer[1:0] == IDX_INPUT);
            end else begin
              state <= ST_RECV;
              cmd_phase <= addr_phase;
              sda_oe_out <= 1'b0;
            end
            addr_phase <= 1'b0;
          end
          ST_SEND: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state <= ST_RACK;
              sda_oe_out <= 1'b0;
              master_acked <= 1'b0;
            end else begin
              sda_oe_out <= !tx_byte[7];
              tx_byte <= {tx_byte[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RACK: begin
            if (master_acked) begin
              state <= ST_SEND;
              tx_byte <= {next_tx[6:0], 1'b0};
              sda_oe_out <= !next_tx[7];
              bit_cnt <= 4'h1;
              input_read <= (pointer[1:0] == IDX_INPUT);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // input snapshot and change alert
  // ----------------------------------------
  logic [7:0] pins_prev;
  logic alert;
  logic [7:0] differs;
  logic changed;

  // only lines set as inputs can raise the alert
  assign differs = (pins_s ^ snapshot) & cfg_reg;
  assign changed = |((pins_s ^ pins_prev) & cfg_reg);

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      snapshot <= 8'h00;
      pins_prev <= 8'h00;
    end else begin
      pins_prev <= pins_s;
      if (input_read) begin
        snapshot <= pins_s;
      end
    end
  end

  // set wins over every release so a change is never lost
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alert <= 1'b0;
    end else if (changed && |differs) begin
      alert <= 1'b1;
    end else if (input_read) begin
      alert <= 1'b0;
    end else if (~|differs) begin
      alert <= 1'b0;
    end else if (foreign_read_ack) begin
      alert <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alert_n_oe_out <= 1'b0;
      expander_port_lines_out <= RST_OUTPUT;
      expander_port_lines_oe_out <= 8'h00;
    end else begin
      alert_n_oe_out <= alert;
      expander_port_lines_out <= out_reg;
      expander_port_lines_oe_out <= ~cfg_reg;
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_out <= 1'b0;
      alert_n_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      alert_n_out <= 1'b0;
    end
  end

endmodule

// >>> test/expander_chk.sv
// assertions on the expander top ports
// bound from the testbench top file
`timescale 1ns/1ps
module expander_chk (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_oe_out,
  input wire logic alert_n_oe_out,
  input wire logic [7:0] expander_port_lines_in,
  input wire logic [7:0] expander_port_lines_out,
  input wire logic [7:0] expander_port_lines_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  AST_RST: assert property ($fell(sys_rst_in) |-> !alert_n_oe_out &&
    expander_port_lines_oe_out == 8'h00 && expander_port_lines_out == 8'hff) else $error("bad reset state");
  AST_RISE: assert property ($rose(alert_n_oe_out) |->
    $past(expander_port_lines_in, 8) != expander_port_lines_in) else $error("alert without change");
  AST_FALL: assert property ($fell(alert_n_oe_out) |->
    $past(expander_port_lines_in, 8) != expander_port_lines_in || $past(scl_in, 8) != scl_in)
    else $error("alert released without cause");
  // a release needs an input or bus event, so quiet inputs and a quiet bus hold the alert
  AST_HOLD: assert property (alert_n_oe_out && $past(scl_in, 6) == scl_in &&
    $past(expander_port_lines_in, 6) == expander_port_lines_in |=> alert_n_oe_out) else $error("alert dropped");
  AST_SDA: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("sda moved with scl high");
  AST_OUTS: assert property ($changed(expander_port_lines_oe_out) ||
    $changed(expander_port_lines_out) |-> !scl_in) else $error("port moved with scl high");
endmodule

// >>> test/i2c_host.sv
// behavioural i2c master, scl stands high between frames
// assumes sda is a pulled-up wire resolved by the testbench
`timescale 1ns/1ps
module i2c_host (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // ----------------------------------------
  // bus conditions, 125 ns bit time
  // ----------------------------------------
  task automatic start;
    sda_low_out = 1'b0;
    scl_out = 1'b1;
    #62 sda_low_out = 1'b1;
    #62 scl_out = 1'b0;
    #31;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    #31 scl_out = 1'b1;
    #62 sda_low_out = 1'b0;
    #62;
  endtask
  // sda moves mid low phase so no false start or stop is seen
  task automatic bit_cyc(input logic b, output logic r);
    sda_low_out = !b;
    #31 scl_out = 1'b1;
    #31 r = sda_in;
    #31 scl_out = 1'b0;
    #32;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(d[i], r);
      q[i] = r;
    end
    bit_cyc(!ack_in, r);
    ack_out = !r;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the expander change alert
// assumes the host model owns scl and the pulled-up sda wire
`timescale 1ns/1ps
module testbench;
  import expander_pkg::*;
  localparam logic [6:0] DEV = {ADDR_BASE, 3'h4};
  logic clock_in, sys_rst_in, scl, host_low, ack, sda_o, sda_oe, alert_n, alert_oe;
  logic [7:0] lines, q, pout, poe;
  int err_count, checks;
  wire sda = !(host_low || sda_oe);
  i2c_host i2c_host_inst (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  expander_input_change_interrupt expander_input_change_interrupt_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .addr_strap_in(3'h4), .expander_port_lines_in(lines),
    .expander_port_lines_out(pout), .expander_port_lines_oe_out(poe), .alert_n_out(alert_n),
    .alert_n_oe_out(alert_oe));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_alert(input logic v);
    int n;
    n = 0;
    while (alert_oe !== v && n < 200) begin
      @(posedge clock_in);
      n++;
    end
    chk("alert", {7'h00, v}, {7'h00, alert_oe});
    if (n == 200) final_report();
  endtask
  task automatic set_lines(input logic [7:0] v);
    @(posedge clock_in);
    #1 lines = v;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic dat);
    i2c_host_inst.start();
    i2c_host_inst.xfer({DEV, 1'b0}, 1'b0, q, ack);
    chk("addr ack", 8'h01, {7'h00, ack});
    i2c_host_inst.xfer(p, 1'b0, q, ack);
    if (dat) i2c_host_inst.xfer(d, 1'b0, q, ack);
    i2c_host_inst.stop();
  endtask
  // a foreign read has the host model pull sda low in the ack slot
  task automatic rd(input logic [6:0] a, input logic fake);
    i2c_host_inst.start();
    i2c_host_inst.xfer({a, 1'b1}, fake, q, ack);
    if (!fake) i2c_host_inst.xfer(8'hff, 1'b0, q, ack);
    i2c_host_inst.stop();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("port out", RST_OUTPUT, pout);
    chk("port oe", ~RST_CONFIG, poe);
    chk("alert", 8'h00, {7'h00, alert_oe});
    chk("sda pin", 8'h00, {7'h00, sda_o});
    chk("alert pin", 8'h00, {7'h00, alert_n});
    wr({6'h00, IDX_CONFIG}, 8'h00, 1'b0);
    rd(DEV, 1'b0);
    chk("config", RST_CONFIG, q);
    $display("test reset done");
  endtask
  task automatic t_read;
    set_lines(8'h5a);
    wait_alert(1'b1);
    chk("alert pin", 8'h00, {7'h00, alert_n});
    wr(PTR_INPUT, 8'h00, 1'b0);
    rd(DEV, 1'b0);
    chk("input", 8'h5a, q);
    wait_alert(1'b0);
    $display("test read done");
  endtask
  task automatic t_return;
    set_lines(8'h5b);
    wait_alert(1'b1);
    set_lines(8'h5a);
    wait_alert(1'b0);
    $display("test return done");
  endtask
  task automatic t_foreign;
    set_lines(8'h5b);
    wait_alert(1'b1);
    rd(7'h20, 1'b1);
    chk("alert", 8'h00, {7'h00, alert_oe});
    set_lines(8'h5a);
    $display("test foreign done");
  endtask
  task automatic t_pointer;
    wr({6'h00, IDX_CONFIG}, 8'h3f, 1'b1);
    chk("port oe", 8'hc0, poe);
    set_lines(8'h5b);
    wait_alert(1'b1);
    rd(7'h20, 1'b1);
    chk("alert", 8'h01, {7'h00, alert_oe});
    wr(PTR_INPUT, 8'h00, 1'b0);
    rd(7'h20, 1'b1);
    chk("alert", 8'h00, {7'h00, alert_oe});
    $display("test pointer done");
  endtask
  // output and polarity registers; a data byte aimed at the input register is dropped
  task automatic t_regs;
    wr({6'h00, IDX_OUTPUT}, 8'ha5, 1'b1);
    chk("port out", 8'ha5, pout);
    rd(DEV, 1'b0);
    chk("output", 8'ha5, q);
    wr({6'h00, IDX_POLARITY}, 8'h0f, 1'b1);
    wr(PTR_INPUT, 8'hff, 1'b1);
    rd(DEV, 1'b0);
    chk("input", 8'h54, q);
    chk("alert", 8'h00, {7'h00, alert_oe});
    wr({6'h00, IDX_POLARITY}, RST_POLARITY, 1'b1);
    $display("test registers done");
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = !clock_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    lines = 8'h00;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    t_reset();
    t_read();
    t_return();
    t_foreign();
    t_pointer();
    t_regs();
    final_report();
  end
endmodule
bind expander_input_change_interrupt expander_chk expander_chk_inst (.clock_in, .sys_rst_in, .scl_in,
  .sda_oe_out, .alert_n_oe_out, .expander_port_lines_in, .expander_port_lines_out, .expander_port_lines_oe_out);
